// ### vpic_pkg.sv
package vpic_pkg;

  // Register indices (byte addresses are four times these)
  localparam logic [7:0] IDX_EN0 = 8'ha8;
  localparam logic [7:0] IDX_EN1 = 8'ha9;
  localparam logic [7:0] IDX_EN2 = 8'haa;
  localparam logic [7:0] IDX_EN3 = 8'hab;
  localparam logic [7:0] IDX_EN4 = 8'hac;
  localparam logic [7:0] IDX_EN5 = 8'had;
  localparam logic [7:0] IDX_LVL_LO = 8'hb8;
  localparam logic [7:0] IDX_LVL_HI = 8'hf8;
  localparam logic [7:0] IDX_EXT_FLAG = 8'ha4;
  localparam logic [7:0] IDX_EXT_TYPE = 8'ha5;
  localparam logic [7:0] IDX_EXT_POL = 8'ha6;
  localparam logic [7:0] IDX_P0_TOG = 8'hae;
  localparam logic [7:0] IDX_P7_TOG = 8'haf;
  localparam logic [7:0] IDX_REQ_LO = 8'hc0;
  localparam logic [7:0] IDX_REQ_HI = 8'hc1;
  localparam logic [7:0] IDX_SVC = 8'hc2;

  localparam int GIE_BIT = 7;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_STEP_SHIFT = 3;
  localparam int SRC_P0_TOG = 4;
  localparam int SRC_P7_TOG = 5;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // Which of the 32 sources are external pins: 0..3 and 28..31
  localparam logic [31:0] EXT_SRC_MASK = 32'hf000_000f;

  typedef enum logic [1:0] {
    VPIC_IDLE = 2'b00,
    VPIC_RESP = 2'b01
  } vpic_bus_state_t;

  typedef struct packed {
    logic valid;
    logic nmi;
    logic [4:0] src;
    logic [1:0] level;
    logic [15:0] vector;
  } vpic_irq_req_t;

  typedef struct packed {
    logic ack;
    logic [4:0] src;
  } vpic_irq_ack_t;

endpackage : vpic_pkg

// ### vpic_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Thirty-two maskable sources, each with own request latch and enable.
// - Hardware reset source always enabled, top rank, never masked.
// - Global enable bit 7 of enable register 0 blocks all maskable.
// - Enables spread six per register; sources 30,31 in register five.
// - Group g holds g, g+8, g+16, g+24; lower number ranks higher.
// - Each group gets two-bit level from both level registers.
// - Among simultaneous requests the higher level is served.
// - Only a strictly higher level than in service may nest.
// - Level-triggered by default, edge mode selectable on external pins.
// - Reset vector 0000H, source n vector 0003H plus 8n.
// - Request flag set on arrival, cleared when core accepts.
// - Pending request held until accepted, reset, or written clear.
// - Acceptance only at instruction end; core makes the call.
// - Vector of selected source presented to the core.
// - Entry takes 5 to 8 machine cycles after instruction ends.
// - Interrupt return releases the in-service level, except in a cycle where ack_ok pushes a new entry.
// - External pins qualified by type and polarity; flags report.
// - Port 7 toggle enable: one bit per pin, resets to 00H.
// - Pin-change request fires when any enabled pin toggles.
// - External flag cleared on service entry or by writing 0.
// - Type bit 0 selects level sensing, 1 edge sensing.
// - With equal levels lower-numbered source wins.
module vpic_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Request sources
  input wire logic hw_reset_req,
  input wire logic [31:0] periph_req,
  input wire logic [7:0] ext_pin,
  input wire logic [7:0] port0_pin,
  input wire logic [7:0] port7_pin,
  // Core side
  input wire vpic_pkg::vpic_irq_ack_t core_ack,
  input wire logic core_interrupt_return,
  output vpic_pkg::vpic_irq_req_t irq_req
);

  function automatic logic [15:0] vec_of(input logic [4:0] n);
    vec_of = vpic_pkg::VEC_BASE +
      16'({11'h000, n} << vpic_pkg::VEC_STEP_SHIFT);
  endfunction : vec_of

  // Map external pin k to its source number
  function automatic int ext_src(input int k);
    ext_src = (k < 4) ? k : k + 24;
  endfunction : ext_src

  logic [7:0] en_q [6];
  logic [7:0] lvl_lo_q, lvl_hi_q;
  logic [7:0] ext_type_q, ext_pol_q, ext_flag_q;
  logic [7:0] p0_tog_q, p7_tog_q;
  logic [7:0] ext_pin_q, p0_pin_q, p7_pin_q;
  logic [31:0] pend_q;
  logic [3:0] svc_q;
  logic [1:0] svc_lvl_q [4];
  logic [2:0] svc_sp_q;
  vpic_pkg::vpic_bus_state_t bst_q;
  logic [31:0] rdata_q;

  // Bus decode; one wait cycle, answer in second cycle
  wire logic [7:0] idx = avs_address[9:2];
  wire logic req_any = avs_read | avs_write;
  wire logic bus_done = req_any && (bst_q == vpic_pkg::VPIC_RESP);
  wire logic wr = avs_write && bus_done && avs_byteenable[0];
  wire logic [7:0] wd = avs_writedata[7:0];
  assign avs_waitrequest = req_any && (bst_q != vpic_pkg::VPIC_RESP);
  assign avs_readdata = rdata_q;

  // External pin qualification
  wire logic [7:0] ext_lvl_hit = ~(ext_pin ^ ext_pol_q);
  wire logic [7:0] ext_edge_hit =
    ext_pol_q & ext_pin & ~ext_pin_q |
    ~ext_pol_q & ~ext_pin & ext_pin_q;
  wire logic [7:0] ext_hit =
    (ext_type_q & ext_edge_hit) | (~ext_type_q & ext_lvl_hit);
  wire logic p0_tog = |(p0_tog_q & (port0_pin ^ p0_pin_q));
  wire logic p7_tog = |(p7_tog_q & (port7_pin ^ p7_pin_q));

  // Raw source events; level sources keep re-setting while asserted
  logic [31:0] src_set;
  always_comb begin
    src_set = periph_req & ~vpic_pkg::EXT_SRC_MASK;
    src_set[vpic_pkg::SRC_P0_TOG] = p0_tog;
    src_set[vpic_pkg::SRC_P7_TOG] = p7_tog;
    for (int k = 0; k < 8; k++) begin
      src_set[ext_src(k)] = ext_hit[k];
    end
  end

  // Gating and arbitration
  logic [31:0] en_vec;
  always_comb begin
    en_vec = '0;
    for (int n = 0; n < 32; n++) begin
      en_vec[n] = en_q[n / 6][n % 6];
    end
  end

  wire logic gie = en_q[0][vpic_pkg::GIE_BIT];
  wire logic [31:0] act = pend_q & en_vec & {32{gie}};
  wire logic [1:0] cur_lvl = svc_lvl_q[svc_sp_q[1:0] - 2'd1];
  wire logic busy = svc_sp_q != 3'd0;

  logic found;
  logic [4:0] win_src;
  logic [1:0] win_lvl;
  always_comb begin
    found = 1'b0;
    win_src = '0;
    win_lvl = '0;
    for (int l = 3; l >= 0; l--) begin
      for (int n = 0; n < 32; n++) begin
        // Index order walks source numbers 0 to 31 in turn: lower number first
        if (!found && act[n] &&
            {lvl_hi_q[n % 8], lvl_lo_q[n % 8]} == 2'(l)) begin
          found = 1'b1;
          win_src = 5'(n);
          win_lvl = 2'(l);
        end
      end
    end
  end
  // sources n and n+8k share group n%8; scan order keeps n first

  wire logic may_nest = !busy || (win_lvl > cur_lvl);
  wire logic ack_ok = core_ack.ack && !svc_q[3];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= '0;
    end else begin
      irq_req.nmi <= hw_reset_req;
      irq_req.valid <= hw_reset_req || (found && may_nest);
      irq_req.src <= hw_reset_req ? 5'd0 : win_src;
      irq_req.level <= hw_reset_req ? 2'd3 : win_lvl;
      irq_req.vector <= hw_reset_req ? vpic_pkg::VEC_RESET :
        vec_of(win_src);
    end
  end

  // the core spends 5 to 8 machine cycles entering; no timer here

  // Pending latches: set beats clear
  logic [31:0] ack_clr, wr_clr;
  always_comb begin
    ack_clr = '0;
    wr_clr = '0;
    if (core_ack.ack) begin
      ack_clr[core_ack.src] = 1'b1;
    end
    if (wr && idx == vpic_pkg::IDX_REQ_LO) begin
      wr_clr[15:0] = ~{avs_writedata[15:0]};
    end
    if (wr && idx == vpic_pkg::IDX_REQ_HI) begin
      wr_clr[31:16] = ~{avs_writedata[15:0]};
    end
  end
  // Level-triggered sources re-set while held, so clears act only once the source drops
  wire logic [31:0] pend_d = (pend_q & ~ack_clr & ~wr_clr) | src_set;

  logic [7:0] ext_ack_clr;
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      ext_ack_clr[k] = ack_clr[ext_src(k)];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= '0;
      ext_flag_q <= vpic_pkg::REG_RST;
    end else begin
      pend_q <= pend_d;
      ext_flag_q <= (ext_flag_q & ~ext_ack_clr &
        ~((wr && idx == vpic_pkg::IDX_EXT_FLAG) ? ~wd : 8'h00))
        | ext_hit;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_pin_q <= '0;
      p0_pin_q <= '0;
      p7_pin_q <= '0;
    end else begin
      ext_pin_q <= ext_pin;
      p0_pin_q <= port0_pin;
      p7_pin_q <= port7_pin;
    end
  end

  // In-service stack of levels, four deep
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      svc_sp_q <= '0;
      svc_q <= '0;
      for (int i = 0; i < 4; i++) begin
        svc_lvl_q[i] <= '0;
      end
    end else if (ack_ok) begin
      svc_lvl_q[svc_sp_q[1:0]] <=
        {lvl_hi_q[core_ack.src[2:0]], lvl_lo_q[core_ack.src[2:0]]};
      svc_sp_q <= svc_sp_q + 3'd1;
      svc_q <= {svc_q[2:0], 1'b1};
    end else if (core_interrupt_return && busy) begin
      svc_sp_q <= svc_sp_q - 3'd1;
      svc_q <= {1'b0, svc_q[3:1]};
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 6; i++) begin
        en_q[i] <= vpic_pkg::REG_RST;
      end
      lvl_lo_q <= vpic_pkg::REG_RST;
      lvl_hi_q <= vpic_pkg::REG_RST;
      ext_type_q <= vpic_pkg::REG_RST;
      ext_pol_q <= vpic_pkg::REG_RST;
      p0_tog_q <= vpic_pkg::REG_RST;
      p7_tog_q <= vpic_pkg::REG_RST;
    end else if (wr) begin
      case (idx)
        vpic_pkg::IDX_EN0: en_q[0] <= wd & 8'hbf;
        vpic_pkg::IDX_EN1: en_q[1] <= wd & 8'h3f;
        vpic_pkg::IDX_EN2: en_q[2] <= wd & 8'h3f;
        vpic_pkg::IDX_EN3: en_q[3] <= wd & 8'h3f;
        vpic_pkg::IDX_EN4: en_q[4] <= wd & 8'h3f;
        vpic_pkg::IDX_EN5: en_q[5] <= wd & 8'h03;
        vpic_pkg::IDX_LVL_LO: lvl_lo_q <= wd;
        vpic_pkg::IDX_LVL_HI: lvl_hi_q <= wd;
        vpic_pkg::IDX_EXT_TYPE: ext_type_q <= wd;
        vpic_pkg::IDX_EXT_POL: ext_pol_q <= wd;
        vpic_pkg::IDX_P0_TOG: p0_tog_q <= wd;
        vpic_pkg::IDX_P7_TOG: p7_tog_q <= wd;
        default: ;
      endcase
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (idx)
      vpic_pkg::IDX_EN0: rd_mux = {24'h0, en_q[0]};
      vpic_pkg::IDX_EN1: rd_mux = {24'h0, en_q[1]};
      vpic_pkg::IDX_EN2: rd_mux = {24'h0, en_q[2]};
      vpic_pkg::IDX_EN3: rd_mux = {24'h0, en_q[3]};
      vpic_pkg::IDX_EN4: rd_mux = {24'h0, en_q[4]};
      vpic_pkg::IDX_EN5: rd_mux = {24'h0, en_q[5]};
      vpic_pkg::IDX_LVL_LO: rd_mux = {24'h0, lvl_lo_q};
      vpic_pkg::IDX_LVL_HI: rd_mux = {24'h0, lvl_hi_q};
      vpic_pkg::IDX_EXT_FLAG: rd_mux = {24'h0, ext_flag_q};
      vpic_pkg::IDX_EXT_TYPE: rd_mux = {24'h0, ext_type_q};
      vpic_pkg::IDX_EXT_POL: rd_mux = {24'h0, ext_pol_q};
      vpic_pkg::IDX_P0_TOG: rd_mux = {24'h0, p0_tog_q};
      vpic_pkg::IDX_P7_TOG: rd_mux = {24'h0, p7_tog_q};
      vpic_pkg::IDX_REQ_LO: rd_mux = {16'h0, pend_q[15:0]};
      vpic_pkg::IDX_REQ_HI: rd_mux = {16'h0, pend_q[31:16]};
      vpic_pkg::IDX_SVC: rd_mux = {25'h0, svc_sp_q, svc_q};
      default: rd_mux = vpic_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bst_q <= vpic_pkg::VPIC_IDLE;
      rdata_q <= '0;
    end else begin
      case (bst_q)
        vpic_pkg::VPIC_IDLE: begin
          if (req_any) begin
            bst_q <= vpic_pkg::VPIC_RESP;
            rdata_q <= rd_mux;
          end
        end
        vpic_pkg::VPIC_RESP: bst_q <= vpic_pkg::VPIC_IDLE;
        default: bst_q <= vpic_pkg::VPIC_IDLE;
      endcase
    end
  end

  // Checks
  property p_nmi_wins;
    @(posedge core_clk) disable iff (!arst_n)
    hw_reset_req |=> irq_req.valid && irq_req.nmi &&
      irq_req.vector == 16'h0000;
  endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("nmi lost");

  property p_gie_off;
    @(posedge core_clk) disable iff (!arst_n)
    !gie && !hw_reset_req |=> !irq_req.valid;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("gie leak");

  property p_vec;
    @(posedge core_clk) disable iff (!arst_n)
    irq_req.valid && !irq_req.nmi |->
      irq_req.vector == 16'h0003 + {8'h0, irq_req.src, 3'b000};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");

  property p_ack_clr;
    @(posedge core_clk) disable iff (!arst_n)
    core_ack.ack && !src_set[core_ack.src] |=> !pend_q[$past(core_ack.src)];
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("flag kept");

  property p_hold;
    @(posedge core_clk) disable iff (!arst_n)
    pend_q != 32'h0 && !core_ack.ack && !wr |=>
      (pend_q & $past(pend_q)) == $past(pend_q);
  endproperty
  a_hold: assert property (p_hold) else $error("pending lost");

  property p_nest;
    @(posedge core_clk) disable iff (!arst_n)
    busy && !hw_reset_req && found && win_lvl <= cur_lvl |=>
      !irq_req.valid;
  endproperty
  a_nest: assert property (p_nest) else $error("bad preempt");

  property p_interrupt_return;
    @(posedge core_clk) disable iff (!arst_n)
    core_interrupt_return && busy && !core_ack.ack |=>
      svc_sp_q == $past(svc_sp_q) - 3'd1;
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("level kept");

  sequence s_wr_p7;
    wr && idx == vpic_pkg::IDX_P7_TOG;
  endsequence
  property p_p7;
    @(posedge core_clk) disable iff (!arst_n)
    s_wr_p7 |=> p7_tog_q == $past(wd);
  endproperty
  a_p7: assert property (p_p7) else $error("p7 enable");

  property p_tog_set;
    @(posedge core_clk) disable iff (!arst_n)
    p7_tog |=> pend_q[vpic_pkg::SRC_P7_TOG];
  endproperty
  a_tog_set: assert property (p_tog_set) else $error("toggle lost");

  // A fresh hit in the same cycle keeps the flag, so only quiet pins clear
  property p_ext_clr;
    @(posedge core_clk) disable iff (!arst_n)
    ext_ack_clr != 8'h00 && ext_hit == 8'h00 && !wr |=>
      (ext_flag_q & $past(ext_ack_clr)) == 8'h00;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("ext flag kept");

  property p_ext_lvl;
    @(posedge core_clk) disable iff (!arst_n)
    !ext_type_q[0] && ext_pin[0] == ext_pol_q[0] |=> ext_flag_q[0];
  endproperty
  a_ext_lvl: assert property (p_ext_lvl) else $error("level missed");

  property p_bus;
    @(posedge core_clk) disable iff (!arst_n)
    req_any && bst_q == vpic_pkg::VPIC_IDLE |-> avs_waitrequest ##1
      (!avs_waitrequest || !req_any);
  endproperty
  a_bus: assert property (p_bus) else $error("bus stall");

endmodule : vpic_ctrl

// ### vpic_core_model.sv
`timescale 1ns/100ps
module vpic_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Controller side
  input wire vpic_pkg::vpic_irq_req_t irq_req,
  output vpic_pkg::vpic_irq_ack_t core_ack,
  output logic core_interrupt_return,
  // Bench control
  input wire logic run,
  input wire logic ret_en
);
  logic [1:0] ilen_q;
  logic [2:0] ent_q;
  logic [2:0] depth_q;
  logic [2:0] cyc_q;
  // Instruction lengths vary so acceptance points wander
  wire last_cyc = (ilen_q == 2'd0) && (ent_q == 3'd0);
  wire take = last_cyc && run && irq_req.valid;
  wire give_back = last_cyc && !take && ret_en && (depth_q != 3'd0);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ilen_q <= 2'd0;
      ent_q <= 3'd0;
      depth_q <= 3'd0;
      cyc_q <= 3'd0;
      core_ack <= '0;
      core_interrupt_return <= 1'b0;
    end else begin
      cyc_q <= cyc_q + 3'd1;
      ilen_q <= (ilen_q == 2'd0) ? cyc_q[1:0] : ilen_q - 2'd1;
      core_ack <= {take, irq_req.src};
      core_interrupt_return <= give_back;
      if (take) begin
        ent_q <= 3'd5;
      end else if (ent_q != 3'd0) begin
        ent_q <= ent_q - 3'd1;
      end
      depth_q <= depth_q + 3'(take) - 3'(give_back);
    end
  end
endmodule : vpic_core_model

// ### vectored_priority_interrupt_controller_tb.sv
`timescale 1ns/100ps
module vectored_priority_interrupt_controller_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic hw_reset_req = 1'b0;
  logic [31:0] periph_req = '0;
  // Idle pins sit high: quiet under the reset low-level setting
  logic [7:0] ext_pin = 8'hff;
  logic [7:0] port0_pin = '0;
  logic [7:0] port7_pin = '0;
  logic run = 1'b0;
  logic ret_en = 1'b1;
  logic core_interrupt_return;
  vpic_pkg::vpic_irq_ack_t core_ack;
  vpic_pkg::vpic_irq_req_t irq_req;
  int miscompares = 0;
  int check_count = 0;
  int acks = 0;
  logic [4:0] ack_src;
  logic [31:0] lfsr = 32'hd8da;
  logic [31:0] d;
  logic [7:0] rst_tab [10] = '{8'ha8, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had,
    8'hb8, 8'hf8, 8'haf, 8'h00};

  always #25 core_clk = ~core_clk;

  vpic_ctrl i_vpic_ctrl (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hw_reset_req(hw_reset_req), .periph_req(periph_req),
    .ext_pin(ext_pin), .port0_pin(port0_pin), .port7_pin(port7_pin),
    .core_ack(core_ack), .core_interrupt_return(core_interrupt_return), .irq_req(irq_req)
  );
  vpic_core_model i_vpic_core_model (
    .core_clk(core_clk), .arst_n(arst_n), .irq_req(irq_req),
    .core_ack(core_ack), .core_interrupt_return(core_interrupt_return), .run(run), .ret_en(ret_en)
  );

  always @(posedge core_clk) begin
    if (core_ack.ack === 1'b1) begin
      acks <= acks + 1;
      ack_src <= core_ack.src;
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic logic [31:0] exp_req(input int n, input logic [1:0] lv);
    return {7'h0, 2'b10, 5'(n), lv, vpic_pkg::VEC_BASE + 16'(n * 8)};
  endfunction : exp_req

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic hang;
    miscompares++;
    $display("ERROR %0t wait ran out", $time);
    final_report();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) hang();
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  // Enables are six bits per register, global enable rides on the first
  task automatic set_en(input logic [35:0] m, input logic g);
    for (int j = 0; j < 6; j++) begin
      bus(1'b1, 8'ha8 + 8'(j), {g && j == 0, 1'b0, m[6*j +: 6]});
    end
  endtask : set_en

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_req.valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (irq_req.valid !== 1'b1) hang();
  endtask : wait_irq

  task automatic wait_ack(input int a0);
    int n;
    n = 0;
    while (acks == a0 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    if (acks == a0) hang();
  endtask : wait_ack

  initial begin
    int n, a, b, c;
    logic [7:0] lo, hi;
    logic [1:0] la, lb;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rst_tab[i]) begin
      bus(1'b0, rst_tab[i], 8'h00);
      chk(d, 32'h0);
    end
    lfsr = nxt(lfsr);
    bus(1'b1, vpic_pkg::IDX_P7_TOG, lfsr[7:0]);
    bus(1'b0, vpic_pkg::IDX_P7_TOG, 8'h00);
    chk(d, {24'h0, lfsr[7:0]});
    for (int k = 0; k < 5; k++) begin
      lfsr = nxt(lfsr);
      n = (k == 0) ? 27 : 6 + int'(lfsr[15:0] % 16'd22);
      set_en(36'(1) << n, 1'b0);
      periph_req[n] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(32'(irq_req.valid), 32'h0);
      set_en(36'(1) << n, 1'b1);
      wait_irq();
      chk(32'(irq_req), exp_req(n, 2'd0));
      // Drop the source first, or the level request would re-arm
      periph_req[n] <= 1'b0;
      bus(1'b0, vpic_pkg::IDX_REQ_LO + 8'(n / 16), 8'h00);
      chk(d, 32'(1) << (n % 16));
      c = acks;
      run <= 1'b1;
      wait_ack(c);
      run <= 1'b0;
      chk(32'(ack_src), 32'(n));
      bus(1'b0, vpic_pkg::IDX_REQ_LO + 8'(n / 16), 8'h00);
      chk(d, 32'h0);
    end
    for (int k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      a = (k == 0) ? 6 : 6 + int'(lfsr[4:0] % 5'd22);
      b = (k == 0) ? 14 : 6 + int'(lfsr[9:5] % 5'd22);
      if (b == a) b = (a == 27) ? 6 : a + 1;
      lo = (k == 0) ? 8'h00 : lfsr[17:10];
      hi = (k == 0) ? 8'h00 : lfsr[25:18];
      bus(1'b1, vpic_pkg::IDX_LVL_LO, lo);
      bus(1'b1, vpic_pkg::IDX_LVL_HI, hi);
      set_en((36'(1) << a) | (36'(1) << b), 1'b1);
      periph_req[a] <= 1'b1;
      periph_req[b] <= 1'b1;
      wait_irq();
      la = {hi[a % 8], lo[a % 8]};
      lb = {hi[b % 8], lo[b % 8]};
      n = (la > lb || (la == lb && a < b)) ? a : b;
      chk(32'(irq_req), exp_req(n, n == a ? la : lb));
      periph_req[a] <= 1'b0;
      periph_req[b] <= 1'b0;
      c = acks;
      run <= 1'b1;
      wait_ack(c);
      chk(32'(ack_src), 32'(n));
      wait_ack(c + 1);
      run <= 1'b0;
      chk(32'(ack_src), 32'(a + b - n));
    end
    ret_en <= 1'b0;
    bus(1'b1, vpic_pkg::IDX_LVL_LO, 8'h40);
    bus(1'b1, vpic_pkg::IDX_LVL_HI, 8'h48);
    set_en(36'h0_0008_0840, 1'b1);
    periph_req[19] <= 1'b1;
    wait_irq();
    periph_req[19] <= 1'b0;
    c = acks;
    run <= 1'b1;
    wait_ack(c);
    periph_req[11] <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk(32'(acks), 32'(c + 1));
    periph_req[11] <= 1'b0;
    periph_req[6] <= 1'b1;
    wait_irq();
    periph_req[6] <= 1'b0;
    wait_ack(c + 1);
    chk(32'(ack_src), 32'd6);
    ret_en <= 1'b1;
    wait_ack(c + 2);
    chk(32'(ack_src), 32'd11);
    run <= 1'b0;
    set_en(36'h20, 1'b1);
    bus(1'b1, vpic_pkg::IDX_P7_TOG, 8'h04);
    port7_pin <= 8'h08;
    repeat (6) @(posedge core_clk);
    chk(32'(irq_req.valid), 32'h0);
    port7_pin <= 8'h0c;
    wait_irq();
    chk(32'(irq_req), exp_req(5, 2'd0));
    bus(1'b1, vpic_pkg::IDX_REQ_LO, 8'h00);
    repeat (4) @(posedge core_clk);
    chk(32'(irq_req.valid), 32'h0);
    set_en(36'h10, 1'b1);
    bus(1'b1, vpic_pkg::IDX_P0_TOG, 8'h80);
    port0_pin <= 8'h80;
    wait_irq();
    chk(32'(irq_req), exp_req(4, 2'd0));
    bus(1'b1, vpic_pkg::IDX_REQ_LO, 8'h00);
    set_en(36'h1, 1'b1);
    // Edge type first, so pin 0 never matches a level setting
    bus(1'b1, vpic_pkg::IDX_EXT_TYPE, 8'h01);
    bus(1'b1, vpic_pkg::IDX_EXT_POL, 8'h01);
    ext_pin <= 8'hfe;
    repeat (2) @(posedge core_clk);
    ext_pin <= 8'hff;
    wait_irq();
    chk(32'(irq_req), exp_req(0, 2'd0));
    bus(1'b0, vpic_pkg::IDX_EXT_FLAG, 8'h00);
    chk(d, 32'h1);
    c = acks;
    run <= 1'b1;
    wait_ack(c);
    run <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(irq_req.valid), 32'h0);
    bus(1'b0, vpic_pkg::IDX_EXT_FLAG, 8'h00);
    chk(d, 32'h0);
    bus(1'b1, vpic_pkg::IDX_EXT_TYPE, 8'h00);
    wait_irq();
    chk(32'(irq_req), exp_req(0, 2'd0));
    ext_pin <= 8'hfe;
    bus(1'b1, vpic_pkg::IDX_EXT_FLAG, 8'h00);
    bus(1'b0, vpic_pkg::IDX_EXT_FLAG, 8'h00);
    chk(d, 32'h0);
    set_en(36'h0, 1'b0);
    hw_reset_req <= 1'b1;
    wait_irq();
    chk(32'({irq_req.valid, irq_req.nmi, irq_req.vector}),
      32'({2'b11, vpic_pkg::VEC_RESET}));
    final_report();
  end
endmodule : vectored_priority_interrupt_controller_tb
